/* File: testbench/alsc_coder_sva.sv */
// checker for the apdu coder, sees the top ports only
// assumes one clock domain; bound onto every alsc_coder at the foot of this file
`timescale 1ns/1ps
module alsc_coder_sva
  import alsc_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic cmd_ready_out,
  input wire logic [7:0] cla_out,
  input wire logic [1:0] channel_out,
  input wire alsc_case_type case_out,
  input wire logic [7:0] lc_out,
  input wire logic cmd_done_out,
  input wire logic [7:0] resp_byte_out,
  input wire logic resp_valid_out,
  input wire logic resp_last_out,
  input wire logic resp_ready_in
);
  logic [7:0] sw1_q;
  logic [8:0] n_q;
  wire took = resp_valid_out && resp_ready_in;
  wire sw2 = resp_valid_out && resp_last_out;
  // sw1_q holds the byte taken just before the closing one
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in)
      sw1_q <= 8'h00;
    else if (took && !resp_last_out)
      sw1_q <= resp_byte_out;
  end
  // n_q counts the bytes of a response before its closing byte
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in || (took && resp_last_out))
      n_q <= 9'h000;
    else if (took)
      n_q <= n_q + 9'h001;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  chk_done_pulse: assert property (cmd_done_out |=> !cmd_done_out)
    else $error("done pulse longer than one cycle");
  chk_busy_refuse: assert property (cmd_done_out || resp_valid_out |-> !cmd_ready_out)
    else $error("command byte accepted while answering");
  chk_chan_field: assert property (cmd_done_out |-> channel_out == cla_out[1:0] && channel_out < CHANNELS)
    else $error("channel not taken from class bits");
  chk_lc_present: assert property (cmd_done_out |-> (lc_out != 8'h00) == case_out[1])
    else $error("lc does not match the command form");
  chk_resp_hold: assert property (resp_valid_out && !resp_ready_in |=>
    resp_valid_out && $stable(resp_byte_out) && $stable(resp_last_out))
    else $error("response byte changed while stalled");
  chk_ready_back: assert property (took && resp_last_out |=>
    !resp_valid_out && cmd_ready_out)
    else $error("not ready for the next command after status");
  chk_plain_sw2: assert property (sw2 && sw1_q inside {8'h90, 8'h93, 8'h64} |-> resp_byte_out == 8'h00)
    else $error("second status byte not zero");
  chk_warn_sw2: assert property (sw2 && sw1_q == 8'h62 |-> resp_byte_out inside {8'h00, [8'h81:8'h83]})
    else $error("bad warning code");
  chk_retry_sw2: assert property (sw2 && sw1_q == 8'h63 |-> resp_byte_out[7:4] == 4'hc)
    else $error("bad retry code");
  chk_exec_sw2: assert property (sw2 && sw1_q == 8'h65 |-> resp_byte_out inside {8'h00, 8'h81})
    else $error("bad execution error code");
  chk_check_sw2: assert property (sw2 && sw1_q inside {8'h6b, 8'h6d, 8'h6e} |-> resp_byte_out == 8'h00)
    else $error("bad checking error code");
  chk_cla_sw2: assert property (sw2 && sw1_q == 8'h68 |-> resp_byte_out inside {8'h00, 8'h81, 8'h82})
    else $error("bad class function code");
  chk_deny_sw2: assert property (sw2 && sw1_q == 8'h69 |-> resp_byte_out inside {8'h00, [8'h81:8'h86]})
    else $error("bad not-allowed code");
  chk_err_nodata: assert property (sw2 && !(sw1_q inside {8'h90, 8'h91, 8'h62}) |-> n_q == 9'h001)
    else $error("data sent with an error status");
  chk_lr_bound: assert property (sw2 |-> n_q inside {[9'h001:9'h101]})
    else $error("response length out of range");
  cov_done: cover property (cmd_done_out);
  cov_pending: cover property (sw2 && sw1_q == 8'h91);
  cov_full: cover property (sw2 && n_q == 9'h101);
  cov_stall: cover property (resp_valid_out && !resp_ready_in);
endmodule

bind alsc_coder alsc_coder_sva #(.CHANNELS(CHANNELS)) u_chk (
  .core_clk_in, .nrst_in, .cmd_ready_out, .cla_out, .channel_out, .case_out, .lc_out,
  .cmd_done_out, .resp_byte_out, .resp_valid_out, .resp_last_out, .resp_ready_in
);

/* File: testbench/alsc_term_model.sv */
// terminal model: offers command bytes, takes response bytes
// assumes the bench calls send() at a clock edge and sets slow_in
`timescale 1ns/1ps
module alsc_term_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic cmd_ready_in,
  output logic [7:0] cmd_byte_out,
  output logic cmd_valid_out,
  output logic cmd_last_out,
  output logic resp_ready_out
);
  initial begin
    cmd_byte_out = 8'h00;
    cmd_valid_out = 1'b0;
    cmd_last_out = 1'b0;
    resp_ready_out = 1'b1;
  end
  // a slow terminal takes a response byte only every other cycle
  always @(posedge clk_in)
    resp_ready_out <= slow_in ? !resp_ready_out : 1'b1;
  // bytes go out in queue order, each held until accepted
  task automatic send(input logic [7:0] q[$]);
    for (int i = 0; i < q.size(); i++) begin
      cmd_byte_out <= q[i];
      cmd_valid_out <= 1'b1;
      cmd_last_out <= (i == q.size() - 1);
      do @(posedge clk_in); while (!cmd_ready_in);
    end
    cmd_valid_out <= 1'b0;
    cmd_last_out <= 1'b0;
    // a released line must not keep looking like the last byte
    cmd_byte_out <= ~q[q.size() - 1];
  endtask
endmodule

/* File: testbench/testbench.sv */
// top bench: terminal model, application stand-in, response scoreboard
// assumes the checker is bound onto alsc_coder from its own file
`timescale 1ns/1ps
module testbench;
  import alsc_pkg::*;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] cmd_byte_in, ins_out, lc_out, resp_byte_out, p1_out, p2_out;
  logic cmd_valid_in, cmd_last_in, cmd_ready_out, cmd_done_out, app_data_valid_out;
  logic app_resp_ready_out, resp_valid_out, resp_last_out, resp_ready_in;
  logic [1:0] channel_out;
  logic [8:0] le_out;
  alsc_case_type case_out;
  logic app_data_ready_in = 1'b0;
  logic app_status_valid_in = 1'b0;
  alsc_status_type app_status_in = ALSC_ST_OK;
  alsc_status_type st = ALSC_ST_OK;
  logic [7:0] app_detail_in = 8'h00;
  logic [7:0] det = 8'h00;
  logic [8:0] app_resp_len_in = 9'h000;
  logic proactive_pending_in = 1'b0;
  logic [7:0] proactive_len_in = 8'h00;
  logic [7:0] app_resp_byte_in = 8'h00;
  logic app_resp_valid_in = 1'b0;
  logic slow_in = 1'b0;
  logic [8:0] exp_q[$];
  logic [31:0] seed = 32'd76;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  int dcnt = 0;

  alsc_coder #(.CHANNELS(2)) DUT (
    .core_clk_in, .nrst_in, .cmd_byte_in, .cmd_valid_in, .cmd_last_in, .cmd_ready_out,
    .cla_out(), .ins_out, .p1_out, .p2_out, .channel_out, .case_out, .lc_out, .le_out,
    .cmd_done_out, .app_data_out(), .app_data_valid_out, .app_data_ready_in,
    .app_status_valid_in, .app_status_in, .app_detail_in, .app_resp_len_in,
    .proactive_pending_in, .proactive_len_in, .app_resp_byte_in, .app_resp_valid_in,
    .app_resp_ready_out, .resp_byte_out, .resp_valid_out, .resp_last_out, .resp_ready_in
  );
  alsc_term_model term (
    .clk_in(core_clk_in), .slow_in, .cmd_ready_in(cmd_ready_out), .cmd_byte_out(cmd_byte_in),
    .cmd_valid_out(cmd_valid_in), .cmd_last_out(cmd_last_in), .resp_ready_out(resp_ready_in)
  );

  always #10 core_clk_in = ~core_clk_in;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] exp_sw(alsc_status_type s, logic [7:0] d, logic p,
                                         logic [7:0] pl);
    case (s)
      ALSC_ST_OK: return p ? {8'h91, pl} : 16'h9000;
      ALSC_ST_BUSY: return 16'h9300;
      ALSC_ST_WARN_NONE: return 16'h6200;
      ALSC_ST_WARN_CORRUPT: return 16'h6281;
      ALSC_ST_WARN_EOF: return 16'h6282;
      ALSC_ST_WARN_INVALID: return 16'h6283;
      ALSC_ST_RETRY: return {12'h63c, d[3:0]};
      ALSC_ST_EXEC_KEEP: return 16'h6400;
      ALSC_ST_EXEC_CHG: return 16'h6500;
      ALSC_ST_EXEC_MEM: return 16'h6581;
      ALSC_ST_WRONG_LEN: return {8'h67, d};
      ALSC_ST_WRONG_P1P2: return 16'h6b00;
      ALSC_ST_BAD_INS: return 16'h6d00;
      ALSC_ST_BAD_CLASS: return 16'h6e00;
      ALSC_ST_TECH: return {8'h6f, d};
      ALSC_ST_CLA_FUNC: return 16'h6800;
      ALSC_ST_NO_CHAN: return 16'h6881;
      ALSC_ST_NO_SM: return 16'h6882;
      default: return (d > 0 && d < 7) ? {8'h69, 8'h80 | d} : 16'h6900;
    endcase
  endfunction

  task automatic cmp_resp(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t resp got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_dec(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t field got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // application stand-in with random stalls on both of its streams
  always @(posedge core_clk_in) begin
    app_data_ready_in <= (rnd() & 3) != 0;
    app_resp_valid_in <= (rnd() & 3) != 0;
    if (app_resp_valid_in && app_resp_ready_out)
      app_resp_byte_in <= app_resp_byte_in + 8'h01;
    if (app_data_valid_out && app_data_ready_in)
      dcnt++;
  end

  always @(posedge core_clk_in) begin
    if (nrst_in && resp_valid_out && resp_ready_in) begin
      if (exp_q.size() == 0)
        exp_q.push_back(9'h1ff);
      cmp_resp({resp_last_out, resp_byte_out}, exp_q.pop_front());
    end
  end

  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      finish_test();
    end
  end

  // frm follows the case code: bit 0 adds Le, bit 1 adds Lc and data; lsw marks a local reject
  task automatic apdu(input logic [7:0] cla, input logic [1:0] frm, input logic [7:0] lc,
                      input logic [7:0] le, input logic [15:0] lsw, input logic [8:0] rlen);
    logic [7:0] q[$];
    logic [15:0] sw;
    logic [7:0] base;
    logic [7:0] pl;
    logic p;
    int lr;
    int n;
    q = {cla, 8'(rnd()), 8'h00, 8'h00};
    if (frm[1]) begin
      q.push_back(lc);
      for (int i = 0; i < lc; i++)
        q.push_back(8'(rnd()));
    end
    if (frm[0])
      q.push_back(le);
    // a byte after Le breaks the length
    if (lsw == 16'h6700 && lc != 8'h00)
      q.push_back(8'h5a);
    p = 1'(rnd());
    pl = 8'(rnd());
    base = 8'(rnd());
    sw = (lsw != 16'h0000) ? lsw : exp_sw(st, det, p, pl);
    lr = 0;
    n = (le == 8'h00) ? 256 : int'(le);
    if (lsw == 16'h0000 && frm[0] && st inside {ALSC_ST_OK, [ALSC_ST_WARN_NONE:ALSC_ST_WARN_INVALID]})
      lr = (rlen < n) ? rlen : n;
    for (int i = 0; i < lr; i++)
      exp_q.push_back({1'b0, base + 8'(i)});
    exp_q.push_back({1'b0, sw[15:8]});
    exp_q.push_back({1'b1, sw[7:0]});
    dcnt = 0;
    slow_in <= 1'(rnd());
    app_status_in <= st;
    app_detail_in <= det;
    app_resp_len_in <= rlen;
    proactive_pending_in <= p;
    proactive_len_in <= pl;
    fork
      term.send(q);
      if (lsw == 16'h0000) begin
        n = 0;
        do @(posedge core_clk_in); while (!cmd_done_out && ++n < 2000);
        cmp_dec({7'h00, channel_out}, {7'h00, cla[1:0]});
        cmp_dec({7'h00, case_out}, {7'h00, frm});
        cmp_dec({1'b0, lc_out}, {1'b0, frm[1] ? lc : 8'h00});
        cmp_dec(le_out, {1'b0, frm[0] ? le : 8'h00});
        cmp_dec({1'b0, ins_out}, {1'b0, q[1]});
        cmp_dec({1'b0, p1_out}, 9'h000);
        cmp_dec({1'b0, p2_out}, 9'h000);
        app_status_valid_in <= 1'b1;
        app_resp_byte_in <= base;
        @(posedge core_clk_in);
        app_status_valid_in <= 1'b0;
      end
    join
    n = 0;
    while (exp_q.size() > 0 && n++ < 3000)
      @(posedge core_clk_in);
    if (exp_q.size() > 0)
      mismatches++;
    if (lsw == 16'h0000)
      cmp_dec(9'(dcnt), {1'b0, frm[1] ? lc : 8'h00});
    repeat (2) @(posedge core_clk_in);
  endtask

  initial begin
    repeat (8) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    @(posedge core_clk_in);
    apdu(8'h40, 2'h0, 8'h00, 8'h00, 16'h6e00, 9'h000);
    apdu(8'h04, 2'h0, 8'h00, 8'h00, 16'h6882, 9'h000);
    apdu(8'h83, 2'h0, 8'h00, 8'h00, 16'h6881, 9'h000);
    apdu(8'h00, 2'h3, 8'h00, 8'h05, 16'h6700, 9'h000);
    apdu(8'h80, 2'h3, 8'h02, 8'h01, 16'h6700, 9'h000);
    apdu(8'h00, 2'h0, 8'h00, 8'h00, 16'h0000, 9'h000);
    apdu(8'h01, 2'h1, 8'h00, 8'h00, 16'h0000, 9'h100);
    apdu(8'ha1, 2'h3, 8'hff, 8'h03, 16'h0000, 9'h005);
    for (int k = 0; k < 38; k++) begin
      st = alsc_status_type'(k % 19);
      det = 8'(rnd()) & 8'h07;
      apdu({k % 3 == 0 ? 4'h0 : (k % 3 == 1 ? 4'h8 : 4'ha), 3'h0, k[0]}, 2'(rnd()),
           8'(rnd() % 8 + 1), 8'(rnd()), 16'h0000, 9'(rnd() % 257));
    end
    finish_test();
  end
endmodule

/* File: verilog/alsc_cfg.svh */
// constants of the apdu length and status coder: status bytes, class byte fields
// assumes inclusion by bare name from the package only; the design modules use its macros without including it
`ifndef ALSC_CFG_SVH
`define ALSC_CFG_SVH

`define ALSC_HDR_BYTES 3'h4
`define ALSC_LE_MAX 9'h100
`define ALSC_CLA_NIB_BASE 4'h0
`define ALSC_CLA_NIB_PROP 4'h8
`define ALSC_CLA_NIB_ALT 4'ha
`define ALSC_CLA_SM_HI 3
`define ALSC_CLA_SM_LO 2
`define ALSC_CLA_CHAN_HI 1
`define ALSC_CLA_CHAN_LO 0
`define ALSC_CHAN_MAX 4

`define ALSC_SW_NONE 8'h00
`define ALSC_SW1_NORMAL 8'h90
`define ALSC_SW1_PENDING 8'h91
`define ALSC_SW1_BUSY 8'h93
`define ALSC_SW1_WARN 8'h62
`define ALSC_SW1_RETRY 8'h63
`define ALSC_SW1_EXEC_KEEP 8'h64
`define ALSC_SW1_EXEC_CHG 8'h65
`define ALSC_SW1_LENGTH 8'h67
`define ALSC_SW1_CLA_FUNC 8'h68
`define ALSC_SW1_NOT_ALLOW 8'h69
`define ALSC_SW1_P1P2 8'h6b
`define ALSC_SW1_INS 8'h6d
`define ALSC_SW1_CLASS 8'h6e
`define ALSC_SW1_TECH 8'h6f
`define ALSC_SW2_CORRUPT 8'h81
`define ALSC_SW2_EOF 8'h82
`define ALSC_SW2_INVALID 8'h83
`define ALSC_SW2_MEMORY 8'h81
`define ALSC_SW2_NO_CHAN 8'h81
`define ALSC_SW2_NO_SM 8'h82
`define ALSC_SW2_RETRY_NIB 4'hc
`define ALSC_SW2_DENY_BASE 8'h80
`define ALSC_DENY_MAX 8'h06

`endif

/* File: verilog/alsc_coder.sv */
// apdu length checker and response builder, card side
// assumes the terminal byte stream and the application are on core_clk_in
`timescale 1ns/1ps

module alsc_coder
  import alsc_pkg::*;
#(
  parameter int CHANNELS = `ALSC_CHAN_MAX
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_last_in,
  output logic cmd_ready_out,
  output logic [7:0] cla_out,
  output logic [7:0] ins_out,
  output logic [7:0] p1_out,
  output logic [7:0] p2_out,
  output logic [1:0] channel_out,
  output alsc_case_type case_out,
  output logic [7:0] lc_out,
  output logic [8:0] le_out,
  output logic cmd_done_out,
  output logic [7:0] app_data_out,
  output logic app_data_valid_out,
  input wire logic app_data_ready_in,
  input wire logic app_status_valid_in,
  input wire alsc_status_type app_status_in,
  input wire logic [7:0] app_detail_in,
  input wire logic [8:0] app_resp_len_in,
  input wire logic proactive_pending_in,
  input wire logic [7:0] proactive_len_in,
  input wire logic [7:0] app_resp_byte_in,
  input wire logic app_resp_valid_in,
  output logic app_resp_ready_out,
  output logic [7:0] resp_byte_out,
  output logic resp_valid_out,
  output logic resp_last_out,
  input wire logic resp_ready_in
);
  generate
    if (CHANNELS < 1 || CHANNELS > `ALSC_CHAN_MAX) begin : g_bad_chan
      $error("alsc_coder: CHANNELS must lie in 1 to 4");
    end
  endgenerate

  localparam logic [2:0] CHAN_LIM = 3'(CHANNELS);

  alsc_sw_if sw_bus ();
  alsc_sw_encoder u_enc (
    .sw(sw_bus)
  );

  alsc_state_type state_q;
  logic [2:0] hdr_idx_q;
  logic [7:0] cnt_q;
  logic [8:0] rem_q;
  logic err_q;
  alsc_status_type err_kind_q;
  alsc_status_type kind_q;
  logic [7:0] detail_q;
  logic pend_q;
  logic [7:0] pend_len_q;
  logic le_present_q;
  logic exec_q;
  logic take;
  logic out_free;
  logic app_free;
  logic [8:0] le_span;
  logic [8:0] lr_d;

  assign take = cmd_valid_in && cmd_ready_out;
  assign out_free = !resp_valid_out || resp_ready_in;
  assign app_free = !app_data_valid_out || app_data_ready_in;
  // Le of 00 stands for the full 256
  assign le_span = (le_out == 9'h000) ? `ALSC_LE_MAX : le_out;

  always_comb begin
    cmd_ready_out = 1'b0;
    unique case (state_q)
      ALSC_S_HDR, ALSC_S_P3, ALSC_S_LE, ALSC_S_SKIP: cmd_ready_out = 1'b1;
      // a command rejected on its class byte is swallowed without troubling the application
      ALSC_S_DATA: cmd_ready_out = err_q || app_free;
      default: cmd_ready_out = 1'b0;
    endcase
  end

  assign app_resp_ready_out = (state_q == ALSC_S_RDATA) && (rem_q != 9'h000) && out_free;

  // in exec the fresh status, not the previous command's, decides whether data may follow
  assign sw_bus.kind = (state_q == ALSC_S_EXEC) ? app_status_in : kind_q;
  assign sw_bus.detail = detail_q;
  assign sw_bus.pend = pend_q;
  assign sw_bus.pend_len = pend_len_q;

  // response length: none without Le, never above Le, none on errors
  always_comb begin
    lr_d = 9'h000;
    if (le_present_q && sw_bus.data_ok) begin
      lr_d = (app_resp_len_in < le_span) ? app_resp_len_in : le_span;
    end
  end

  // command parsing and response sequencing
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      state_q <= ALSC_S_HDR;
      hdr_idx_q <= 3'h0;
      cnt_q <= 8'h00;
      rem_q <= 9'h000;
      le_present_q <= 1'b0;
      case_out <= ALSC_CASE_1;
      lc_out <= 8'h00;
      le_out <= 9'h000;
    end else begin
      unique case (state_q)
        ALSC_S_HDR: if (take) begin
          hdr_idx_q <= hdr_idx_q + 3'h1;
          if (hdr_idx_q == `ALSC_HDR_BYTES - 3'h1) begin
            hdr_idx_q <= 3'h0;
            le_present_q <= 1'b0;
            lc_out <= 8'h00;
            le_out <= 9'h000;
            case_out <= ALSC_CASE_1;
            state_q <= cmd_last_in ? ALSC_S_EXEC : ALSC_S_P3;
          end else if (cmd_last_in) begin
            hdr_idx_q <= 3'h0;
            state_q <= ALSC_S_EXEC;
          end
        end
        ALSC_S_P3: if (take) begin
          if (cmd_last_in) begin
            le_out <= {1'b0, cmd_byte_in};
            le_present_q <= 1'b1;
            case_out <= ALSC_CASE_2;
            state_q <= ALSC_S_EXEC;
          end else begin
            lc_out <= cmd_byte_in;
            cnt_q <= cmd_byte_in;
            case_out <= ALSC_CASE_3;
            state_q <= (cmd_byte_in == 8'h00) ? ALSC_S_SKIP : ALSC_S_DATA;
          end
        end
        ALSC_S_DATA: if (take) begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            state_q <= cmd_last_in ? ALSC_S_EXEC : ALSC_S_LE;
          end else if (cmd_last_in) begin
            state_q <= ALSC_S_EXEC;
          end
        end
        ALSC_S_LE: if (take) begin
          le_out <= {1'b0, cmd_byte_in};
          le_present_q <= 1'b1;
          case_out <= ALSC_CASE_4;
          state_q <= cmd_last_in ? ALSC_S_EXEC : ALSC_S_SKIP;
        end
        ALSC_S_SKIP: if (take && cmd_last_in) begin
          state_q <= ALSC_S_EXEC;
        end
        ALSC_S_EXEC: begin
          if (err_q) begin
            rem_q <= 9'h000;
            state_q <= ALSC_S_SW1;
          end else if (app_status_valid_in) begin
            rem_q <= lr_d;
            state_q <= ALSC_S_RDATA;
          end
        end
        ALSC_S_RDATA: begin
          if (rem_q == 9'h000) begin
            state_q <= ALSC_S_SW1;
          end else if (app_resp_valid_in && out_free) begin
            rem_q <= rem_q - 9'h001;
          end
        end
        ALSC_S_SW1: if (out_free) begin
          state_q <= ALSC_S_SW2;
        end
        ALSC_S_SW2: if (out_free) begin
          state_q <= ALSC_S_DRAIN;
        end
        // busy or not, the block returns here ready for the next command
        ALSC_S_DRAIN: if (out_free) begin
          state_q <= ALSC_S_HDR;
        end
        default: state_q <= ALSC_S_HDR;
      endcase
    end
  end

  // header capture and class screening; first problem found is reported, a cut header beating a class fault on the same byte
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cla_out <= 8'h00;
      ins_out <= 8'h00;
      p1_out <= 8'h00;
      p2_out <= 8'h00;
      channel_out <= 2'h0;
      err_q <= 1'b0;
      err_kind_q <= ALSC_ST_OK;
    end else if (state_q == ALSC_S_DRAIN) begin
      err_q <= 1'b0;
    end else if (take) begin
      if (state_q == ALSC_S_HDR) begin
        unique case (hdr_idx_q)
          3'h0: begin
            cla_out <= cmd_byte_in;
            channel_out <= cmd_byte_in[`ALSC_CLA_CHAN_HI:`ALSC_CLA_CHAN_LO];
            if (cmd_byte_in[7:4] != `ALSC_CLA_NIB_BASE &&
                cmd_byte_in[7:4] != `ALSC_CLA_NIB_PROP &&
                cmd_byte_in[7:4] != `ALSC_CLA_NIB_ALT) begin
              err_q <= 1'b1;
              err_kind_q <= ALSC_ST_BAD_CLASS;
            end else if (cmd_byte_in[`ALSC_CLA_SM_HI:`ALSC_CLA_SM_LO] != 2'h0) begin
              err_q <= 1'b1;
              err_kind_q <= ALSC_ST_NO_SM;
            end else if ({1'b0, cmd_byte_in[1:0]} >= CHAN_LIM) begin
              err_q <= 1'b1;
              err_kind_q <= ALSC_ST_NO_CHAN;
            end
          end
          3'h1: ins_out <= cmd_byte_in;
          3'h2: p1_out <= cmd_byte_in;
          3'h3: p2_out <= cmd_byte_in;
          default: ins_out <= ins_out;
        endcase
      end
      if (!err_q) begin
        // header cut short, Lc of zero, data cut short, or bytes after Le
        if ((state_q == ALSC_S_HDR && cmd_last_in && hdr_idx_q != 3'h3) ||
            (state_q == ALSC_S_P3 && !cmd_last_in && cmd_byte_in == 8'h00) ||
            (state_q == ALSC_S_DATA && cmd_last_in && cnt_q != 8'h01) ||
            (state_q == ALSC_S_LE && !cmd_last_in)) begin
          err_q <= 1'b1;
          err_kind_q <= ALSC_ST_WRONG_LEN;
        end
      end
    end
  end

  // status latched when the command ends, held until the status bytes leave
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      kind_q <= ALSC_ST_OK;
      detail_q <= 8'h00;
      pend_q <= 1'b0;
      pend_len_q <= 8'h00;
    end else if (state_q == ALSC_S_EXEC) begin
      if (err_q) begin
        kind_q <= err_kind_q;
        detail_q <= 8'h00;
        pend_q <= 1'b0;
      end else if (app_status_valid_in) begin
        kind_q <= app_status_in;
        detail_q <= app_detail_in;
        pend_q <= proactive_pending_in;
        pend_len_q <= proactive_len_in;
      end
    end
  end

  // done strobe marks only the first exec cycle
  always_ff @(posedge core_clk_in) begin
    exec_q <= nrst_in && (state_q == ALSC_S_EXEC);
  end

  assign cmd_done_out = (state_q == ALSC_S_EXEC) && !err_q && !exec_q;

  // command data goes to the application untouched
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      app_data_out <= 8'h00;
      app_data_valid_out <= 1'b0;
    end else begin
      if (app_data_ready_in) begin
        app_data_valid_out <= 1'b0;
      end
      if (take && state_q == ALSC_S_DATA && !err_q) begin
        app_data_out <= cmd_byte_in;
        app_data_valid_out <= 1'b1;
      end
    end
  end

  // single output stage: data bytes, then SW1, then SW2 marked last
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      resp_byte_out <= 8'h00;
      resp_valid_out <= 1'b0;
      resp_last_out <= 1'b0;
    end else begin
      if (resp_ready_in) begin
        resp_valid_out <= 1'b0;
        resp_last_out <= 1'b0;
      end
      if (app_resp_ready_out && app_resp_valid_in) begin
        resp_byte_out <= app_resp_byte_in;
        resp_valid_out <= 1'b1;
      end else if (state_q == ALSC_S_SW1 && out_free) begin
        resp_byte_out <= sw_bus.sw1;
        resp_valid_out <= 1'b1;
      end else if (state_q == ALSC_S_SW2 && out_free) begin
        resp_byte_out <= sw_bus.sw2;
        resp_valid_out <= 1'b1;
        resp_last_out <= 1'b1;
      end
    end
  end
endmodule

/* File: verilog/alsc_pkg.sv */
// types shared by the apdu length and status coder modules
// assumes alsc_cfg.svh on the include path
package alsc_pkg;
  `include "alsc_cfg.svh"

  typedef enum logic [4:0] {
    ALSC_ST_OK = 5'h00,
    ALSC_ST_BUSY = 5'h01,
    ALSC_ST_WARN_NONE = 5'h02,
    ALSC_ST_WARN_CORRUPT = 5'h03,
    ALSC_ST_WARN_EOF = 5'h04,
    ALSC_ST_WARN_INVALID = 5'h05,
    ALSC_ST_RETRY = 5'h06,
    ALSC_ST_EXEC_KEEP = 5'h07,
    ALSC_ST_EXEC_CHG = 5'h08,
    ALSC_ST_EXEC_MEM = 5'h09,
    ALSC_ST_WRONG_LEN = 5'h0a,
    ALSC_ST_WRONG_P1P2 = 5'h0b,
    ALSC_ST_BAD_INS = 5'h0c,
    ALSC_ST_BAD_CLASS = 5'h0d,
    ALSC_ST_TECH = 5'h0e,
    ALSC_ST_CLA_FUNC = 5'h0f,
    ALSC_ST_NO_CHAN = 5'h10,
    ALSC_ST_NO_SM = 5'h11,
    ALSC_ST_NOT_ALLOWED = 5'h12
  } alsc_status_type;

  typedef enum logic [3:0] {
    ALSC_S_HDR = 4'h0,
    ALSC_S_P3 = 4'h1,
    ALSC_S_DATA = 4'h2,
    ALSC_S_LE = 4'h3,
    ALSC_S_SKIP = 4'h4,
    ALSC_S_EXEC = 4'h5,
    ALSC_S_RDATA = 4'h6,
    ALSC_S_SW1 = 4'h7,
    ALSC_S_SW2 = 4'h8,
    ALSC_S_DRAIN = 4'h9
  } alsc_state_type;

  typedef enum logic [1:0] {
    ALSC_CASE_1 = 2'h0,
    ALSC_CASE_2 = 2'h1,
    ALSC_CASE_3 = 2'h2,
    ALSC_CASE_4 = 2'h3
  } alsc_case_type;
endpackage

/* File: verilog/alsc_sw_encoder.sv */
// status word encoder: maps a status kind and detail to sw1, sw2
// assumes detail is stable while the sequencer reads sw1 and sw2
`timescale 1ns/1ps
module alsc_sw_encoder
  import alsc_pkg::*;
(
  alsc_sw_if.enc sw
);
  always_comb begin
    sw.sw1 = `ALSC_SW1_TECH;
    sw.sw2 = `ALSC_SW_NONE;
    sw.data_ok = 1'b0;
    unique case (sw.kind)
      ALSC_ST_OK: begin
        sw.data_ok = 1'b1;
        if (sw.pend) begin
          sw.sw1 = `ALSC_SW1_PENDING;
          sw.sw2 = sw.pend_len;
        end else begin
          sw.sw1 = `ALSC_SW1_NORMAL;
        end
      end
      ALSC_ST_BUSY: sw.sw1 = `ALSC_SW1_BUSY;
      ALSC_ST_WARN_NONE: begin
        sw.sw1 = `ALSC_SW1_WARN;
        sw.data_ok = 1'b1;
      end
      ALSC_ST_WARN_CORRUPT: begin
        sw.sw1 = `ALSC_SW1_WARN;
        sw.sw2 = `ALSC_SW2_CORRUPT;
        sw.data_ok = 1'b1;
      end
      ALSC_ST_WARN_EOF: begin
        sw.sw1 = `ALSC_SW1_WARN;
        sw.sw2 = `ALSC_SW2_EOF;
        sw.data_ok = 1'b1;
      end
      ALSC_ST_WARN_INVALID: begin
        sw.sw1 = `ALSC_SW1_WARN;
        sw.sw2 = `ALSC_SW2_INVALID;
        sw.data_ok = 1'b1;
      end
      ALSC_ST_RETRY: begin
        sw.sw1 = `ALSC_SW1_RETRY;
        sw.sw2 = {`ALSC_SW2_RETRY_NIB, sw.detail[3:0]};
      end
      ALSC_ST_EXEC_KEEP: sw.sw1 = `ALSC_SW1_EXEC_KEEP;
      ALSC_ST_EXEC_CHG: sw.sw1 = `ALSC_SW1_EXEC_CHG;
      ALSC_ST_EXEC_MEM: begin
        sw.sw1 = `ALSC_SW1_EXEC_CHG;
        sw.sw2 = `ALSC_SW2_MEMORY;
      end
      ALSC_ST_WRONG_LEN: begin
        sw.sw1 = `ALSC_SW1_LENGTH;
        sw.sw2 = sw.detail;
      end
      ALSC_ST_WRONG_P1P2: sw.sw1 = `ALSC_SW1_P1P2;
      ALSC_ST_BAD_INS: sw.sw1 = `ALSC_SW1_INS;
      ALSC_ST_BAD_CLASS: sw.sw1 = `ALSC_SW1_CLASS;
      ALSC_ST_TECH: sw.sw2 = sw.detail;
      ALSC_ST_CLA_FUNC: sw.sw1 = `ALSC_SW1_CLA_FUNC;
      ALSC_ST_NO_CHAN: begin
        sw.sw1 = `ALSC_SW1_CLA_FUNC;
        sw.sw2 = `ALSC_SW2_NO_CHAN;
      end
      ALSC_ST_NO_SM: begin
        sw.sw1 = `ALSC_SW1_CLA_FUNC;
        sw.sw2 = `ALSC_SW2_NO_SM;
      end
      ALSC_ST_NOT_ALLOWED: begin
        sw.sw1 = `ALSC_SW1_NOT_ALLOW;
        // out-of-range reasons collapse to "no information"
        if (sw.detail != `ALSC_SW_NONE && sw.detail <= `ALSC_DENY_MAX) begin
          sw.sw2 = `ALSC_SW2_DENY_BASE | sw.detail;
        end
      end
      default: sw.sw1 = `ALSC_SW1_TECH;
    endcase
  end
endmodule

/* File: verilog/alsc_sw_if.sv */
// carrier between the sequencer and the status word encoder
// assumes both ends sit on the same clock; the encoder is purely combinational
`timescale 1ns/1ps
interface alsc_sw_if;
  import alsc_pkg::*;
  alsc_status_type kind;
  logic [7:0] detail;
  logic pend;
  logic [7:0] pend_len;
  logic [7:0] sw1;
  logic [7:0] sw2;
  logic data_ok;

  modport enc (input kind, input detail, input pend, input pend_len,
               output sw1, output sw2, output data_ok);
  modport user (output kind, output detail, output pend, output pend_len,
                input sw1, input sw2, input data_ok);
endinterface
